// *** logic/hups_hold_timer.sv ***
// Timer that reports a condition held for LIMIT seconds in a row.
`timescale 1ns/1ps
module hups_hold_timer
  import hups_pkg::*;
#(
  parameter int unsigned LIMIT = 1
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  hups_tmr_if.timer tmr
);

  // The first tick may land just after the condition starts, so one
  // extra tick keeps every hold at least LIMIT full seconds long.
  localparam int unsigned W = $clog2(LIMIT + 2);
  localparam logic [W-1:0] LIM = W'(LIMIT + 1);

  logic [W-1:0] count;

  // Any break in the condition restarts the hold from zero.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !tmr.cond) begin
      count <= '0;
    end else if (tmr.tick && count != LIM) begin
      count <= count + 1'b1;
    end
  end

  // Done only while the condition still holds.
  assign tmr.done = tmr.cond && (count == LIM);

endmodule

// *** logic/hups_pkg.sv ***
// Shared constants for the rooftop unit protection sequencer.
package hups_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ONE_SEC_NS = 1000000000;
  localparam int unsigned TICK_DIV_DEF = ONE_SEC_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Protection windows in seconds of the slow timebase, trip limits, circuit count
  // ----------------------------------------------------------------
  localparam int unsigned AIRFLOW_S = 40;
  localparam int unsigned FILTER_S = 120;
  localparam int unsigned OVF_S = 6;
  localparam int unsigned TRIP_S = 1;
  localparam int unsigned INHIBIT_S = 180;
  localparam int unsigned WINDOW_DAYS = 3;
  localparam int unsigned WINDOW_S_DEF = WINDOW_DAYS * 24 * 3600;
  localparam logic [1:0] OVF_MAX = 2'h2;
  localparam logic [2:0] CONSEC_MAX = 3'h4;
  localparam int unsigned NCIRC = 2;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EXH_SP_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int unsigned CTRL_RST_BIT = 0;
  localparam int unsigned CTRL_VENT_BIT = 1;
  localparam logic [7:0] EXH_SP_RST = 8'h19;
  localparam int unsigned ST_AIR_BIT = 0;
  localparam int unsigned ST_FLT_BIT = 1;
  localparam int unsigned ST_OVF_BIT = 2;
  localparam int unsigned ST_OVFL_BIT = 3;
  localparam int unsigned ST_LOCK_LSB = 4;
  localparam int unsigned ST_LEAD_BIT = 6;
  localparam int unsigned ST_LL_BIT = 7;
  localparam int unsigned ST_CNT_LSB = 8;

endpackage

// *** logic/hups_tmr_if.sv ***
// Carrier between the sequencer and one continuous-hold timer.
`timescale 1ns/1ps
interface hups_tmr_if;
  logic tick;
  logic cond;
  logic done;
  modport timer(input tick, input cond, output done);
  modport user(output tick, output cond, input done);
endinterface

// *** logic/hups_top.sv ***
// Protection and sequencing core of a packaged rooftop unit controller.
`timescale 1ns/1ps

module hups_top
  import hups_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_DIV_DEF,
  parameter int unsigned WINDOW_S = WINDOW_S_DEF
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic zone_present_in,
  input wire logic fan_request_in,
  input wire logic [1:0] cool_stage_in,
  input wire logic airflow_proving_switch_in,
  input wire logic filter_switch_in,
  input wire logic drain_overflow_input_in,
  input wire logic [1:0] compressor_disable_input_in,
  input wire logic [1:0] low_pressure_input_in,
  input wire logic [1:0] comp_current_in,
  input wire logic [7:0] damper_pos_in,
  input wire logic lead_lag_select_in,
  input wire logic manual_reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic supply_fan_out,
  output logic [1:0] comp_out,
  output logic exhaust_fan_out,
  output logic filter_out,
  output logic service_out,
  output logic diag_out,
  output logic lead_circuit_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 23;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;

  // Damper position moves slowly, so a one-cycle skew across bits is harmless.
  always_ff @(posedge sys_clk_in) begin
    sync_a <= {zone_present_in, fan_request_in, cool_stage_in,
               airflow_proving_switch_in, filter_switch_in,
               drain_overflow_input_in, compressor_disable_input_in,
               low_pressure_input_in, comp_current_in, damper_pos_in,
               lead_lag_select_in, manual_reset_in};
    sync_b <= sync_a;
  end

  logic zone_s, fan_s, air_s, flt_s, ovf_s, ll_en, man_s;
  logic [1:0] cool_s, dis_ok, lp_ok, cur_s;
  logic [7:0] damper_s;
  assign {zone_s, fan_s, cool_s, air_s, flt_s, ovf_s, dis_ok, lp_ok, cur_s,
          damper_s, ll_en, man_s} = sync_b;

  // ----------------------------------------------------------------
  // One-second timebase
  // ----------------------------------------------------------------
  logic [31:0] div_cnt;
  logic tick;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in || div_cnt == 32'(TICK_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 32'h1;
    end
  end
  assign tick = (div_cnt == 32'(TICK_DIV - 1));

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic link_reset, vent_ovr, clr_any;
  logic [7:0] exh_sp;
  logic [31:0] status;

  // The link reset is a one-cycle pulse; the override bit is a level.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      link_reset <= 1'b0;
      vent_ovr <= 1'b0;
      exh_sp <= EXH_SP_RST;
    end else begin
      link_reset <= wr_in && addr_in == CTRL_OFS && wdata_in[CTRL_RST_BIT];
      if (wr_in && addr_in == CTRL_OFS) begin
        vent_ovr <= wdata_in[CTRL_VENT_BIT];
      end
      if (wr_in && addr_in == EXH_SP_OFS) begin
        exh_sp <= wdata_in[7:0];
      end
    end
  end
  assign clr_any = man_s || link_reset;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || !rd_in) begin
      rdata_out <= '0;
    end else begin
      case (addr_in)
        CTRL_OFS: rdata_out <= {30'h0, vent_ovr, 1'b0};
        EXH_SP_OFS: rdata_out <= {24'h0, exh_sp};
        STATUS_OFS: rdata_out <= status;
        default: rdata_out <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Airflow proving and filter
  // ----------------------------------------------------------------
  logic air_lock, ovf_shut, ovf_lock, run_ok, flash;
  logic [1:0] ovf_cnt;
  hups_tmr_if air_if();
  hups_tmr_if flt_if();

  assign air_if.tick = tick;
  assign air_if.cond = supply_fan_out && !air_s;
  assign flt_if.tick = tick;
  assign flt_if.cond = supply_fan_out && flt_s;
  hups_hold_timer #(.LIMIT(AIRFLOW_S)) u_air (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .tmr(air_if));
  hups_hold_timer #(.LIMIT(FILTER_S)) u_flt (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .tmr(flt_if));

  // A new airflow fault wins over a reset in the same cycle.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      air_lock <= 1'b0;
    end else if (air_if.done) begin
      air_lock <= 1'b1;
    end else if (clr_any) begin
      air_lock <= 1'b0;
    end
  end

  // The filter is advisory and takes no part in run_ok.
  assign run_ok = zone_s && !air_lock && !ovf_shut && !ovf_lock;

  // ----------------------------------------------------------------
  // Condensate overflow
  // ----------------------------------------------------------------
  logic [31:0] win_cnt;
  hups_tmr_if otrip_if();
  hups_tmr_if oclr_if();

  assign otrip_if.tick = tick;
  assign otrip_if.cond = ovf_s && !ovf_shut;
  assign oclr_if.tick = tick;
  assign oclr_if.cond = !ovf_s && ovf_shut;
  hups_hold_timer #(.LIMIT(OVF_S)) u_otrip (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .tmr(otrip_if));
  hups_hold_timer #(.LIMIT(OVF_S)) u_oclr (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .tmr(oclr_if));

  // Shutdown follows the overflow, with a 6 s hold on each edge.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ovf_shut <= 1'b0;
    end else if (otrip_if.done) begin
      ovf_shut <= 1'b1;
    end else if (oclr_if.done) begin
      ovf_shut <= 1'b0;
    end
  end

  // The window opens at the first shutdown and drops the count on expiry.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ovf_cnt <= '0;
      win_cnt <= '0;
      ovf_lock <= 1'b0;
    end else begin
      if (otrip_if.done) begin
        if (ovf_cnt != 2'h3) begin
          ovf_cnt <= ovf_cnt + 2'h1;
        end
        if (ovf_cnt == 2'h0) begin
          win_cnt <= 32'(WINDOW_S);
        end
      end else if (clr_any) begin
        ovf_cnt <= '0;
        win_cnt <= '0;
      end else if (tick && win_cnt != 32'h0) begin
        win_cnt <= win_cnt - 32'h1;
        if (win_cnt == 32'h1) begin
          ovf_cnt <= '0;
        end
      end
      if (otrip_if.done && ovf_cnt >= OVF_MAX) begin
        ovf_lock <= 1'b1;
      end else if (clr_any) begin
        ovf_lock <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compressor circuits
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  logic [1:0] dem, want, lock;
  logic lead;

  for (genvar i = 0; i < NCIRC; i++) begin : g_circ
    logic [7:0] inh;
    logic [7:0] run_s;
    logic [2:0] dis_n;
    logic [2:0] lp_n;
    logic trip;
    hups_tmr_if dis_if();
    hups_tmr_if lp_if();
    hups_tmr_if hp_if();

    assign dis_if.tick = tick;
    assign dis_if.cond = comp_out[i] && !dis_ok[i];
    assign lp_if.tick = tick;
    assign lp_if.cond = comp_out[i] && !lp_ok[i];
    assign hp_if.tick = tick;
    assign hp_if.cond = comp_out[i] && !cur_s[i] && dem[i];
    hups_hold_timer #(.LIMIT(TRIP_S)) u_dis (.sys_clk_in(sys_clk_in),
      .reset_in(reset_in), .tmr(dis_if));
    hups_hold_timer #(.LIMIT(TRIP_S)) u_lp (.sys_clk_in(sys_clk_in),
      .reset_in(reset_in), .tmr(lp_if));
    hups_hold_timer #(.LIMIT(TRIP_S)) u_hp (.sys_clk_in(sys_clk_in),
      .reset_in(reset_in), .tmr(hp_if));

    assign trip = dis_if.done || lp_if.done;
    assign dem[i] = (lead == 1'(i)) ? cool_s[0] : cool_s[1];
    // A stopped compressor starts only with its disable contacts closed.
    assign want[i] = run_ok && dem[i] && !lock[i] && inh == 8'h0 &&
                     !trip && !hp_if.done &&
                     (comp_out[i] || dis_ok[i]);

    // The inhibit is loaded one second longer so a partial first tick
    // never shortens it below the full minimum.
    always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
        inh <= '0;
      end else if (trip) begin
        inh <= 8'(INHIBIT_S + 1);
      end else if (tick && inh != 8'h0) begin
        inh <= inh - 8'h1;
      end
    end

    // Seconds of the current run, capped at the early-run window.
    always_ff @(posedge sys_clk_in) begin
      if (reset_in || !comp_out[i]) begin
        run_s <= '0;
      end else if (tick && run_s != 8'(INHIBIT_S)) begin
        run_s <= run_s + 8'h1;
      end
    end

    // Trip counters and the per-circuit lockout; a trip beats a reset.
    always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
        dis_n <= '0;
        lp_n <= '0;
        lock[i] <= 1'b0;
      end else begin
        if (dis_if.done && run_s < 8'(INHIBIT_S)) begin
          dis_n <= dis_n + 3'h1;
        end else if (clr_any || run_s == 8'(INHIBIT_S)) begin
          dis_n <= '0;
        end
        if (lp_if.done) begin
          lp_n <= lp_n + 3'h1;
        end else if (clr_any || cool_s == 2'h0) begin
          lp_n <= '0;
        end
        if ((dis_if.done && run_s < 8'(INHIBIT_S) &&
             dis_n == CONSEC_MAX - 3'h1) ||
            (lp_if.done && lp_n == CONSEC_MAX - 3'h1) ||
            hp_if.done) begin
          lock[i] <= 1'b1;
        end else if (clr_any) begin
          lock[i] <= 1'b0;
        end
      end
    end

    a_start_block: assert property (!comp_out[i] && !dis_ok[i]
      |=> !comp_out[i]) else $error("start despite open disable");
    a_inhibit_hold: assert property (inh != 8'h0 |=> !comp_out[i])
      else $error("compressor ran during inhibit");
    a_trip_stop: assert property (trip |=> !comp_out[i] ##1 inh != 8'h0)
      else $error("trip did not stop compressor");
  end

  // Lead swaps only on a satisfied load of the running lead circuit.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      lead <= 1'b0;
    end else if (ll_en && comp_out[lead] && !cool_s[0]) begin
      lead <= !lead;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      flash <= 1'b0;
    end else if (tick) begin
      flash <= !flash;
    end
  end

  // Every output is registered so the field side never sees glitches.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      supply_fan_out <= 1'b0;
      comp_out <= '0;
      exhaust_fan_out <= 1'b0;
      filter_out <= 1'b0;
      service_out <= 1'b0;
      diag_out <= 1'b0;
      lead_circuit_out <= 1'b0;
    end else begin
      supply_fan_out <= run_ok && fan_s;
      comp_out <= want;
      exhaust_fan_out <= run_ok && damper_s >= exh_sp &&
                         (supply_fan_out || vent_ovr);
      filter_out <= flt_if.done;
      service_out <= air_lock ? flash : (ovf_lock || lock != 2'h0);
      diag_out <= air_lock || ovf_lock || lock != 2'h0;
      lead_circuit_out <= lead;
    end
  end

  always_comb begin
    status = '0;
    status[ST_AIR_BIT] = air_lock;
    status[ST_FLT_BIT] = filter_out;
    status[ST_OVF_BIT] = ovf_shut;
    status[ST_OVFL_BIT] = ovf_lock;
    status[ST_LOCK_LSB +: 2] = lock;
    status[ST_LEAD_BIT] = lead;
    status[ST_LL_BIT] = ll_en;
    status[ST_CNT_LSB +: 2] = ovf_cnt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_stop_all;
    !supply_fan_out && comp_out == 2'h0 && !exhaust_fan_out;
  endsequence
  sequence s_air_fault;
    air_if.done ##1 air_lock;
  endsequence

  a_no_run_stop: assert property (!run_ok |=> s_stop_all)
    else $error("unit ran without permission");
  a_air_lockout: assert property (s_air_fault |=> s_stop_all ##0 diag_out)
    else $error("airflow fault not acted on");
  a_air_latched: assert property (air_lock && !clr_any |=> air_lock)
    else $error("airflow lockout dropped");
  a_filter_fan: assert property (filter_out |-> $past(supply_fan_out))
    else $error("filter output without fan");
  a_ovf_shutdown: assert property ($rose(ovf_shut) |=> s_stop_all)
    else $error("overflow shutdown incomplete");
  a_ovf_latched: assert property (ovf_lock && !clr_any |=> ovf_lock)
    else $error("overflow lockout dropped");
  a_exhaust_on: assert property (run_ok && damper_s >= exh_sp &&
    supply_fan_out |=> exhaust_fan_out)
    else $error("exhaust fan not started");
  a_lead_fixed: assert property (!ll_en |=> $stable(lead))
    else $error("lead swapped while disabled");

endmodule

// *** sim/hups_field_model.sv ***
// Field side model: airflow switch, compressor current, option wire.
`timescale 1ns/1ps
module hups_field_model (
  input wire logic sys_clk_in,
  input wire logic supply_fan_in,
  input wire logic [1:0] comp_in,
  input wire logic air_block_in,
  input wire logic [1:0] hp_open_in,
  input wire logic ll_cut_in,
  output logic airflow_out = 1'b0,
  output logic [1:0] current_out = 2'h0,
  output logic ll_sel_out
);
  // ----------------------------------------------------------------
  // Switches and sensors
  // ----------------------------------------------------------------
  // The proving switch follows the fan one cycle late; a blocked duct
  // keeps it open. An open high pressure switch breaks the contactor
  // coil, so no current flows although the output is driven.
  always @(posedge sys_clk_in) begin
    airflow_out <= supply_fan_in & ~air_block_in;
    current_out <= comp_in & ~hp_open_in;
  end

  // A cut selection wire floats high, which the unit reads as enable.
  assign ll_sel_out = ll_cut_in;
endmodule

// *** sim/hups_top_tb_top.sv ***
// Self-checking bench for the rooftop unit protection sequencer.
`timescale 1ns/1ps
// One comparison; a mismatch is printed and counted at once.
`define CHK(n, e, s) begin \
  compares++; \
  if ((s) !== (e)) begin \
    miscompares++; \
    $display("unexpected %s exp %h seen %h", n, e, s); \
  end \
end
module hups_top_tb_top
  import hups_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TD = 10;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  typedef struct {int sel; logic [31:0] exp; logic [31:0] msk;} hups_note_s;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic zone_present_in = 1'b0;
  logic fan_request_in = 1'b0;
  logic [1:0] cool_stage_in = 2'h0;
  logic airflow_proving_switch_in;
  logic filter_switch_in = 1'b0;
  logic drain_overflow_input_in = 1'b0;
  logic [1:0] compressor_disable_input_in = 2'h3;
  logic [1:0] low_pressure_input_in = 2'h3;
  logic [1:0] comp_current_in;
  logic [7:0] damper_pos_in = 8'h00;
  logic lead_lag_select_in;
  logic manual_reset_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic supply_fan_out, exhaust_fan_out, filter_out;
  logic service_out, diag_out, lead_circuit_out;
  logic [1:0] comp_out;
  logic air_block = 1'b0;
  logic [1:0] hp_open = 2'h0;
  logic ll_cut = 1'b0;
  logic [31:0] seed = 32'hD466;
  int miscompares = 0;
  int compares = 0;
  hups_note_s notes[$];
  string nm[8] = '{"rdata", "fan", "comp", "exhaust", "filter", "service",
    "diag", "lead"};
  logic [31:0] ov[8];

  always #2.5 sys_clk_in = ~sys_clk_in;

  // Outputs gathered by index so that a note names what it checks.
  always_comb begin
    ov = '{rdata_out, 32'(supply_fan_out), 32'(comp_out),
      32'(exhaust_fan_out), 32'(filter_out), 32'(service_out),
      32'(diag_out), 32'(lead_circuit_out)};
  end

  hups_top #(.TICK_DIV(TD), .WINDOW_S(50)) dut (
    .sys_clk_in, .reset_in, .zone_present_in, .fan_request_in,
    .cool_stage_in, .airflow_proving_switch_in, .filter_switch_in,
    .drain_overflow_input_in, .compressor_disable_input_in,
    .low_pressure_input_in, .comp_current_in, .damper_pos_in,
    .lead_lag_select_in, .manual_reset_in, .addr_in, .wdata_in, .wr_in,
    .rd_in, .rdata_out, .supply_fan_out, .comp_out, .exhaust_fan_out,
    .filter_out, .service_out, .diag_out, .lead_circuit_out);

  hups_field_model field (.sys_clk_in, .supply_fan_in(supply_fan_out),
    .comp_in(comp_out), .air_block_in(air_block), .hp_open_in(hp_open),
    .ll_cut_in(ll_cut), .airflow_out(airflow_proving_switch_in),
    .current_out(comp_current_in), .ll_sel_out(lead_lag_select_in));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic tick(int n);
    cyc(n * TD);
  endtask

  task automatic note(int s, logic [31:0] e, logic [31:0] m = ALL);
    notes.push_back('{s, e, m});
  endtask

  // Bounded wait; the caller's note then catches a missed change.
  task automatic wait_for(int s, logic [31:0] e, int lim);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end while (k < lim && ov[s] !== e);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    cyc(1);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    cyc(1);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
    cyc(1);
    addr_in <= a;
    rd_in <= 1'b1;
    cyc(1);
    rd_in <= 1'b0;
    note(0, e, m);
  endtask

  task automatic pulse_manual();
    cyc(1);
    manual_reset_in <= 1'b1;
    cyc(5);
    manual_reset_in <= 1'b0;
  endtask

  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Scoreboard: every queued note is compared, oldest first, with the settled outputs.
  always @(negedge sys_clk_in) begin
    while (notes.size() > 0) begin
      hups_note_s n;
      n = notes.pop_front();
      `CHK(nm[n.sel], n.exp, ov[n.sel] & n.msk)
    end
  end

  // The whole sequence needs about 20000 cycles; this leaves room.
  initial begin
    cyc(60000);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int sp;
    int pos;
    cyc(6);
    reset_in <= 1'b0;
    cyc(1);
    note(2, 0);
    note(7, 0);
    rd(EXH_SP_OFS, 32'h19, ALL);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'h0, ALL);
    fan_request_in <= 1'b1;
    cool_stage_in <= 2'h1;
    cyc(40);
    note(1, 0);
    zone_present_in <= 1'b1;
    wait_for(2, 1, 40);
    note(2, 1);
    // Damper against setpoint: both edges, then random positions.
    for (int i = 0; i < 12; i++) begin
      if (i == 6) wr(EXH_SP_OFS, 32'h32);
      seed = xs(seed);
      sp = (i < 6) ? 25 : 50;
      pos = (i % 6 == 0) ? sp - 1 : (i % 6 == 1) ? sp : seed % 101;
      cyc(1);
      damper_pos_in <= 8'(pos);
      cyc(6);
      note(3, 32'(pos >= sp));
    end
    filter_switch_in <= 1'b1;
    tick(115);
    note(4, 0);
    tick(8);
    note(4, 1);
    note(2, 1);
    fan_request_in <= 1'b0;
    cool_stage_in <= 2'h0;
    damper_pos_in <= 8'h3C;
    cyc(8);
    note(4, 0);
    note(3, 0);
    filter_switch_in <= 1'b0;
    wr(CTRL_OFS, 32'h2);
    cyc(6);
    note(3, 1);
    wr(CTRL_OFS, 32'h0);
    // Circuit two is held open before its start.
    compressor_disable_input_in <= 2'h1;
    fan_request_in <= 1'b1;
    cool_stage_in <= 2'h3;
    cyc(40);
    note(2, 1);
    compressor_disable_input_in <= 2'h3;
    wait_for(2, 3, 40);
    cyc(1);
    compressor_disable_input_in <= 2'h2;
    low_pressure_input_in <= 2'h1;
    tick(3);
    note(2, 0);
    compressor_disable_input_in <= 2'h3;
    low_pressure_input_in <= 2'h3;
    tick(170);
    note(2, 0);
    wait_for(2, 3, 250);
    note(2, 3);
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      low_pressure_input_in <= 2'h1;
      tick(3);
      low_pressure_input_in <= 2'h3;
      wait_for(2, 3, 2000);
      note(2, 32'(i < 2 ? 3 : 1));
    end
    note(6, 1);
    rd(STATUS_OFS, 32'h20, 32'h30);
    pulse_manual();
    wait_for(2, 3, 2000);
    note(2, 3);
    cyc(1);
    hp_open <= 2'h1;
    tick(3);
    note(2, 2);
    rd(STATUS_OFS, 32'h10, 32'h30);
    hp_open <= 2'h0;
    wr(CTRL_OFS, 32'h1);
    wait_for(2, 3, 2000);
    note(6, 0);
    cyc(1);
    air_block <= 1'b1;
    tick(37);
    note(6, 0);
    tick(5);
    note(2, 0);
    note(6, 1);
    rd(STATUS_OFS, 32'h1, 32'h1);
    wait_for(5, 1, 30);
    note(5, 1);
    wait_for(5, 0, 30);
    note(5, 0);
    cyc(1);
    air_block <= 1'b0;
    tick(20);
    note(6, 1);
    pulse_manual();
    wait_for(6, 0, 20);
    note(6, 0);
    // Three shutdowns inside the window; the third one locks.
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      drain_overflow_input_in <= 1'b1;
      tick(4);
      note(1, 1);
      tick(4);
      note(1, 0);
      drain_overflow_input_in <= 1'b0;
      tick(4);
      note(1, 0);
      tick(4);
      note(1, 32'(i < 2));
    end
    rd(STATUS_OFS, 32'h8, 32'h8);
    note(5, 1);
    note(6, 1);
    cyc(1);
    reset_in <= 1'b1;
    cyc(3);
    reset_in <= 1'b0;
    wait_for(1, 1, 40);
    note(7, 0);
    rd(STATUS_OFS, 32'h0, 32'h8);
    cool_stage_in <= 2'h1;
    wait_for(2, 1, 2000);
    cyc(1);
    cool_stage_in <= 2'h0;
    cyc(6);
    note(7, 0);
    ll_cut <= 1'b1;
    cool_stage_in <= 2'h1;
    wait_for(2, 1, 2000);
    cyc(1);
    cool_stage_in <= 2'h0;
    cyc(6);
    note(7, 1);
    cool_stage_in <= 2'h1;
    wait_for(2, 2, 2000);
    note(2, 2);
    rd(STATUS_OFS, 32'hC0, 32'hC0);
    // Four early disable trips on the running lead circuit lock it.
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      compressor_disable_input_in <= 2'h1;
      tick(3);
      note(2, 0);
      compressor_disable_input_in <= 2'h3;
      wait_for(2, 2, 2000);
      note(2, 32'(i < 3 ? 2 : 0));
    end
    note(6, 1);
    rd(STATUS_OFS, 32'h20, 32'h30);
    cyc(3);
    complete_run();
  end
endmodule
